// file: pls_link_model.sv
/*
 * Transmit side model: strobes one ordered set at a time while a
 * sequence runs. Assumes the block's clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pls_link_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Sequence and pacing
	input wire logic send_fts,
	input wire logic send_ts1,
	input wire logic slow,
	// Set sent strobe
	output logic os_sent
);
	logic [1:0] gap;

	// One set every other cycle, spaced further when slow
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			os_sent <= 1'b0;
			gap <= 2'h0;
		end else if (!(send_fts || send_ts1)) begin
			os_sent <= 1'b0;
			gap <= 2'h0;
		end else begin
			os_sent <= gap == 2'h0 && !os_sent;
			if (os_sent)
				gap <= slow ? 2'h3 : 2'h0;
			else if (gap != 2'h0)
				gap <= gap - 2'h1;
		end
	end
endmodule : pls_link_model

`default_nettype wire

// file: pls_os_seq.sv
/*
 * Exit sequencer: counts FTS ordered sets for an L0s exit or TS1 sets
 * for an L1 exit. Assumes the transmitter pulses os_sent once per set.
 */
`timescale 1ns/1ps
`default_nettype none

module pls_os_seq #(
	parameter int CNT_W = 13,
	parameter int FTS_NORM = 8,
	parameter int TS1_NORM = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Exit requests
	input wire logic exit_l0s,
	input wire logic exit_l1,
	input wire logic ext_sync,
	input wire logic os_sent,
	// Sequence outputs
	output logic send_fts,
	output logic send_ts1,
	output logic seq_done
);

	// Counts must fit the counter
	if (pls_pkg::FTS_XSYNC >= (1 << CNT_W) || FTS_NORM < 1 ||
		FTS_NORM >= (1 << CNT_W) || TS1_NORM < 1 ||
		TS1_NORM >= (1 << CNT_W)) begin : g_bad
		$error("pls_os_seq: ordered-set counts do not fit");
	end

	pls_pkg::pls_os_state_t state;
	pls_pkg::pls_os_state_t next_state;
	logic [CNT_W-1:0] left;
	logic [CNT_W-1:0] next_left;
	logic [CNT_W-1:0] fts_n;
	logic [CNT_W-1:0] ts1_n;
	logic last_os;

	// Set counts picked by the extended synch bit
	assign fts_n = ext_sync ? CNT_W'(pls_pkg::FTS_XSYNC) : CNT_W'(FTS_NORM);
	assign ts1_n = ext_sync ? CNT_W'(pls_pkg::TS1_XSYNC) : CNT_W'(TS1_NORM);
	assign last_os = os_sent && (left == CNT_W'(1));

	// Next state and count
	always_comb begin
		next_state = state;
		next_left = left;
		unique case (state)
			pls_pkg::PLS_OS_IDLE: begin
				if (exit_l0s) begin
					next_state = pls_pkg::PLS_OS_FTS;
					next_left = fts_n;
				end else if (exit_l1) begin
					next_state = pls_pkg::PLS_OS_TS1;
					next_left = ts1_n;
				end
			end
			pls_pkg::PLS_OS_FTS, pls_pkg::PLS_OS_TS1: begin
				if (last_os) begin
					next_state = pls_pkg::PLS_OS_IDLE;
				end
				if (os_sent) begin
					next_left = left - CNT_W'(1);
				end
			end
			default: begin
				next_state = pls_pkg::PLS_OS_IDLE;
			end
		endcase
	end

	// State, count and registered outputs
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= pls_pkg::PLS_OS_IDLE;
			left <= '0;
			send_fts <= 1'b0;
			send_ts1 <= 1'b0;
			seq_done <= 1'b0;
		end else begin
			state <= next_state;
			left <= next_left;
			send_fts <= (next_state == pls_pkg::PLS_OS_FTS);
			send_ts1 <= (next_state == pls_pkg::PLS_OS_TS1);
			seq_done <= (state != pls_pkg::PLS_OS_IDLE) && last_os;
		end
	end

endmodule : pls_os_seq

`default_nettype wire

// file: pls_pkg.sv
/*
 * Package for the link status register bank: offsets, field positions,
 * reset values, ordered-set counts and the exit-sequence states.
 * Assumes an 8-bit byte address on the register port, 32-bit data.
 */
`default_nettype none

package pls_pkg;

	// Register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Byte offsets of the register words
	localparam logic [7:0] OFF_DEV = 8'he8;
	localparam logic [7:0] OFF_CAP = 8'hec;
	localparam logic [7:0] OFF_LNK = 8'hf0;

	// Device control / status word fields
	localparam int ERR_N = 4;
	localparam int DC_EN_LO = 0;
	localparam int DS_ERR_LO = 16;
	localparam int DS_AUX = 20;

	// Link capability word fields
	localparam int CAP_SPEED_LO = 0;
	localparam int CAP_WIDTH_LO = 4;
	localparam int CAP_ASPM_LO = 10;
	localparam int CAP_L0S_LO = 12;
	localparam int CAP_L1_LO = 15;

	// Link control / status word fields
	localparam int LC_ASPM_LO = 0;
	localparam int LC_LDIS = 4;
	localparam int LC_RETRAIN = 5;
	localparam int LC_CCLK = 6;
	localparam int LC_XSYNC = 7;
	localparam int LS_SPEED_LO = 16;
	localparam int LS_WIDTH_LO = 20;
	localparam int LS_TERR = 26;
	localparam int LS_TRAIN = 27;

	// Encodings and reset values
	localparam logic [3:0] SPEED_2G5 = 4'h1;
	localparam logic [5:0] LANE_X1 = 6'h01;
	localparam logic [1:0] ASPM_SUP_RST = 2'h1;
	localparam logic [2:0] L0S_LAT_RST = 3'h3;
	localparam logic [2:0] L1_LAT_RST = 3'h0;
	localparam logic [1:0] ASPM_CTL_RST = 2'h0;
	localparam logic [3:0] ERR_RST = 4'h0;
	localparam logic [3:0] ERR_EN_RST = 4'h0;
	localparam logic AUX_RST = 1'b1;

	// Ordered sets sent on exit with extended synch set
	localparam int FTS_XSYNC = 4096;
	localparam int TS1_XSYNC = 1024;

	// Exit sequencer states, Gray coded along idle-fts-ts1
	typedef enum logic [1:0] {
		PLS_OS_IDLE = 2'b00,
		PLS_OS_FTS = 2'b01,
		PLS_OS_TS1 = 2'b11
	} pls_os_state_t;

endpackage : pls_pkg

`default_nettype wire

// file: pls_regs.sv
/*
 * Link status register bank of a PCI Express endpoint: device error
 * status, link capabilities, link control and link status words.
 * Assumes a synchronous register port with one-cycle strobes, event
 * inputs from error detection and link training logic, and a loader
 * (serial management bus or EEPROM) that may replace capability defaults.
 */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pls_regs #(
	parameter int FTS_NORM = 8,
	parameter int TS1_NORM = 16,
	parameter int CNT_W = 13
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [pls_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pls_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pls_pkg::DATA_W-1:0] reg_rdata,
	// Capability loader
	input wire logic cap_load,
	input wire logic [1:0] cap_load_aspm,
	input wire logic [2:0] cap_load_l0s,
	input wire logic [2:0] cap_load_l1,
	// Error detection events
	input wire logic [pls_pkg::ERR_N-1:0] err_det,
	input wire logic aux_pwr_det,
	// Link training state
	input wire logic train_active,
	input wire logic train_err,
	input wire logic train_done,
	input wire logic [3:0] neg_speed,
	input wire logic [5:0] neg_width,
	// Power state exit handshake
	input wire logic exit_l0s,
	input wire logic exit_l1,
	input wire logic os_sent,
	// Controls toward the link
	output logic aspm_l0s_en,
	output logic aspm_l1_en,
	output logic rx_l0s_en,
	output logic link_disable,
	output logic retrain_link,
	output logic common_clk,
	output logic [pls_pkg::ERR_N-1:0] err_msg,
	output logic send_fts,
	output logic send_ts1,
	output logic exit_done
);

	// Counter must be wide enough for the longest sequence
	if (CNT_W < 13 || CNT_W > 16) begin : g_bad_cnt
		$error("pls_regs: CNT_W must be 13 to 16");
	end

	// Address compare, used by every word decode
	function automatic logic pls_hit(
		input logic [pls_pkg::ADDR_W-1:0] addr,
		input logic [pls_pkg::ADDR_W-1:0] off
	);
		pls_hit = (addr == off);
	endfunction : pls_hit

	// Stored state
	logic [pls_pkg::ERR_N-1:0] err_flag;
	logic [pls_pkg::ERR_N-1:0] err_en;
	logic aux_det;
	logic [1:0] aspm_sup;
	logic [2:0] l0s_lat;
	logic [2:0] l1_lat;
	logic [1:0] aspm_ctl;
	logic ext_sync;
	logic train_err_flag;
	logic training;
	logic [3:0] link_speed;
	logic [5:0] link_width;

	// Word decodes
	wire hit_dev = pls_hit(reg_addr, pls_pkg::OFF_DEV);
	wire hit_cap = pls_hit(reg_addr, pls_pkg::OFF_CAP);
	wire hit_lnk = pls_hit(reg_addr, pls_pkg::OFF_LNK);
	wire wr_dev = reg_wr && hit_dev;
	wire wr_lnk = reg_wr && hit_lnk;

	// Write-one-to-clear mask for the error flags
	wire [pls_pkg::ERR_N-1:0] err_clr =
		wr_dev ? reg_wdata[pls_pkg::DS_ERR_LO +: pls_pkg::ERR_N] : '0;

	// Error flags, one per class; set beats clear
	for (genvar i = 0; i < pls_pkg::ERR_N; i++) begin : g_err
		wire next_err = err_det[i] | (err_flag[i] & ~err_clr[i]);

		always_ff @(posedge ref_clk or negedge rst_b) begin
			if (!rst_b) begin
				err_flag[i] <= pls_pkg::ERR_RST[i];
			end else begin
				err_flag[i] <= next_err;
			end
		end
	end

	// Reporting enables and error messages gated by them
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_en <= pls_pkg::ERR_EN_RST;
			err_msg <= '0;
		end else begin
			if (wr_dev) begin
				err_en <= reg_wdata[pls_pkg::DC_EN_LO +: pls_pkg::ERR_N];
			end
			err_msg <= err_det & err_en;
		end
	end

	// Auxiliary power detection follows its input
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_det <= pls_pkg::AUX_RST;
		end else begin
			aux_det <= aux_pwr_det;
		end
	end

	// Capability defaults, replaced only by the loader
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aspm_sup <= pls_pkg::ASPM_SUP_RST;
			l0s_lat <= pls_pkg::L0S_LAT_RST;
			l1_lat <= pls_pkg::L1_LAT_RST;
		end else if (cap_load) begin
			aspm_sup <= cap_load_aspm;
			l0s_lat <= cap_load_l0s;
			l1_lat <= cap_load_l1;
		end
	end

	// Link control fields written by software
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aspm_ctl <= pls_pkg::ASPM_CTL_RST;
			link_disable <= 1'b0;
			retrain_link <= 1'b0;
			common_clk <= 1'b0;
			ext_sync <= 1'b0;
		end else if (wr_lnk) begin
			aspm_ctl <= reg_wdata[pls_pkg::LC_ASPM_LO +: 2];
			link_disable <= reg_wdata[pls_pkg::LC_LDIS];
			retrain_link <= reg_wdata[pls_pkg::LC_RETRAIN];
			common_clk <= reg_wdata[pls_pkg::LC_CCLK];
			ext_sync <= reg_wdata[pls_pkg::LC_XSYNC];
		end
	end

	// Power state permissions toward the link
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aspm_l0s_en <= 1'b0;
			aspm_l1_en <= 1'b0;
			rx_l0s_en <= 1'b1;
		end else begin
			aspm_l0s_en <= aspm_ctl[0];
			aspm_l1_en <= aspm_ctl[1];
			rx_l0s_en <= 1'b1;
		end
	end

	// Training error: set on error, cleared on entry to L0
	wire next_terr = train_err | (train_err_flag & ~train_done);

	// Training progress and negotiated link values
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			train_err_flag <= 1'b0;
			training <= 1'b0;
			link_speed <= pls_pkg::SPEED_2G5;
			link_width <= pls_pkg::LANE_X1;
		end else begin
			train_err_flag <= next_terr;
			training <= train_active;
			if (train_done) begin
				link_speed <= neg_speed;
				link_width <= neg_width;
			end
		end
	end

	// Exit sequencer for FTS and TS1 ordered sets
	pls_os_seq #(
		.CNT_W(CNT_W),
		.FTS_NORM(FTS_NORM),
		.TS1_NORM(TS1_NORM)
	) u_os_seq (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.exit_l0s(exit_l0s),
		.exit_l1(exit_l1),
		.ext_sync(ext_sync),
		.os_sent(os_sent),
		.send_fts(send_fts),
		.send_ts1(send_ts1),
		.seq_done(exit_done)
	);

	// Device control and status word
	logic [pls_pkg::DATA_W-1:0] word_dev;
	always_comb begin
		word_dev = '0;
		word_dev[pls_pkg::DC_EN_LO +: pls_pkg::ERR_N] = err_en;
		word_dev[pls_pkg::DS_ERR_LO +: pls_pkg::ERR_N] = err_flag;
		word_dev[pls_pkg::DS_AUX] = aux_det;
	end

	// Link capability word; speed and width are constants
	logic [pls_pkg::DATA_W-1:0] word_cap;
	always_comb begin
		word_cap = '0;
		word_cap[pls_pkg::CAP_SPEED_LO +: 4] = pls_pkg::SPEED_2G5;
		word_cap[pls_pkg::CAP_WIDTH_LO +: 6] = pls_pkg::LANE_X1;
		word_cap[pls_pkg::CAP_ASPM_LO +: 2] = aspm_sup;
		word_cap[pls_pkg::CAP_L0S_LO +: 3] = l0s_lat;
		word_cap[pls_pkg::CAP_L1_LO +: 3] = l1_lat;
	end

	// Link control and status word
	logic [pls_pkg::DATA_W-1:0] word_lnk;
	always_comb begin
		word_lnk = '0;
		word_lnk[pls_pkg::LC_ASPM_LO +: 2] = aspm_ctl;
		word_lnk[pls_pkg::LC_LDIS] = link_disable;
		word_lnk[pls_pkg::LC_RETRAIN] = retrain_link;
		word_lnk[pls_pkg::LC_CCLK] = common_clk;
		word_lnk[pls_pkg::LC_XSYNC] = ext_sync;
		word_lnk[pls_pkg::LS_SPEED_LO +: 4] = link_speed;
		word_lnk[pls_pkg::LS_WIDTH_LO +: 6] = link_width;
		word_lnk[pls_pkg::LS_TERR] = train_err_flag;
		word_lnk[pls_pkg::LS_TRAIN] = training;
	end

	// Read select; unmapped addresses read zero
	wire [pls_pkg::DATA_W-1:0] rd_sel =
		hit_dev ? word_dev :
		hit_cap ? word_cap :
		hit_lnk ? word_lnk : '0;

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_sel : '0;
		end
	end

endmodule : pls_regs

`default_nettype wire

// file: pls_regs_assertions.sv
/*
 * Port checker for the link status register bank.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pls_regs_assertions (
	// Clock, reset and register port
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [pls_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pls_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [pls_pkg::DATA_W-1:0] reg_rdata,
	// Events and link side
	input wire logic [pls_pkg::ERR_N-1:0] err_det,
	input wire logic [pls_pkg::ERR_N-1:0] err_msg,
	input wire logic exit_l0s,
	input wire logic exit_l1,
	input wire logic send_fts,
	input wire logic send_ts1,
	input wire logic exit_done,
	input wire logic rx_l0s_en,
	input wire logic aspm_l0s_en,
	input wire logic aspm_l1_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Exit sequencer not running
	wire idle = !send_fts && !send_ts1;

	// Register read data
	property p_rd0; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("read data not idle");
	property p_cap;
		reg_rd && reg_addr == 8'hec |=> reg_rdata[31:18] == 14'h0 &&
			reg_rdata[9:0] == 10'h011;
	endproperty
	a_cap: assert property (p_cap) else $error("capability fixed bits");
	property p_ctl;
		reg_rd && reg_addr == 8'hf0 |=> reg_rdata[15:8] == 8'h0 &&
			reg_rdata[3:2] == 2'h0 && reg_rdata[31:28] == 4'h0;
	endproperty
	a_ctl: assert property (p_ctl) else $error("link word zero bits");
	property p_dev; reg_rd && reg_addr == 8'he8 |=> reg_rdata[31:21] == 11'h0; endproperty
	a_dev: assert property (p_dev) else $error("status zero bits");

	// Control and event outputs
	property p_rx; rx_l0s_en; endproperty
	a_rx: assert property (p_rx) else $error("receiver l0s off");
	property p_msg; (err_msg & ~$past(err_det)) == 4'h0; endproperty
	a_msg: assert property (p_msg) else $error("report without error");
	property p_aspm;
		reg_wr && reg_addr == 8'hf0 |-> ##2
			{aspm_l1_en, aspm_l0s_en} == $past(reg_wdata[1:0], 2);
	endproperty
	a_aspm: assert property (p_aspm) else $error("aspm enables");

	// Exit sequences
	property p_fts; exit_l0s && idle |=> send_fts && !send_ts1; endproperty
	a_fts: assert property (p_fts) else $error("fts start");
	property p_ts1; exit_l1 && !exit_l0s && idle |=> send_ts1 && !send_fts; endproperty
	a_ts1: assert property (p_ts1) else $error("ts1 start");
	property p_done; $fell(send_fts) || $fell(send_ts1) |-> ##[0:1] exit_done; endproperty
	a_done: assert property (p_done) else $error("no exit done");

	// Main scenarios reached
	c_done: cover property (exit_done);
	c_msg: cover property (err_msg != 4'h0);
	c_rd: cover property (reg_rd && reg_addr == 8'he8);
endmodule : pls_regs_assertions

bind pls_regs pls_regs_assertions chk_u (.ref_clk, .rst_b, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .err_det, .err_msg,
	.exit_l0s, .exit_l1, .send_fts, .send_ts1, .exit_done, .rx_l0s_en,
	.aspm_l0s_en, .aspm_l1_en);

`default_nettype wire

// file: pls_regs_tb_top.sv
/*
 * Testbench of the link status register bank with a link model.
 * Assumes a 25 MHz clock and the design's default counts.
 */
`timescale 1ns/1ps
`default_nettype none

module pls_regs_tb_top;
	localparam int FN = 8;
	localparam int TN = 16;
	logic ref_clk, rst_b, reg_wr, reg_rd, cap_load, aux_pwr_det, slow;
	logic train_active, train_err, train_done, exit_l0s, exit_l1;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, r, w, seed;
	logic [1:0] cap_load_aspm;
	logic [2:0] cap_load_l0s, cap_load_l1;
	logic [3:0] err_det, err_msg, neg_speed, det, fl;
	logic [5:0] neg_width;
	logic os_sent, aspm_l0s_en, aspm_l1_en, rx_l0s_en, link_disable;
	logic retrain_link, common_clk, send_fts, send_ts1, exit_done, rd_seen;
	logic [31:0] exp_q[$];
	int failures, checked;

	pls_regs #(.FTS_NORM(FN), .TS1_NORM(TN)) dut_u (.ref_clk, .rst_b,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cap_load,
		.cap_load_aspm, .cap_load_l0s, .cap_load_l1, .err_det, .aux_pwr_det,
		.train_active, .train_err, .train_done, .neg_speed, .neg_width,
		.exit_l0s, .exit_l1, .os_sent, .aspm_l0s_en, .aspm_l1_en, .rx_l0s_en,
		.link_disable, .retrain_link, .common_clk, .err_msg, .send_fts,
		.send_ts1, .exit_done);
	pls_link_model link_u (.ref_clk, .rst_b, .send_fts, .send_ts1, .slow,
		.os_sent);

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task summarize();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// One bus cycle; a read notes d as its expected data
	task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		if (!wr)
			exp_q.push_back(d);
		@(posedge ref_clk);
	endtask : acc

	task idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask : idle

	task rst();
		rst_b <= 1'b0;
		aux_pwr_det <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		acc(0, 8'he8, 32'h0010_0000);
		acc(0, 8'hec, 32'h0000_3411);
		acc(0, 8'hf0, 32'h0011_0000);
		acc(0, 8'h40, 32'h0);
		idle(2);
		$display("test reset done");
	endtask : rst

	// Exit sequence, counting sets of the right kind
	task ex(input logic l1, input logic sl, input int n);
		int k;
		int c;
		c = 0;
		slow <= sl;
		// Both requests on a slow l0s exit: l0s must win
		exit_l0s <= !l1;
		exit_l1 <= l1 | sl;
		@(posedge ref_clk);
		// Opposite request while running must be ignored
		exit_l0s <= l1;
		exit_l1 <= !l1;
		@(posedge ref_clk);
		exit_l0s <= 1'b0;
		exit_l1 <= 1'b0;
		for (k = 0; k < 20000 && exit_done !== 1'b1; k++) begin
			@(negedge ref_clk);
			if (os_sent && (l1 ? send_ts1 : send_fts))
				c++;
		end
		if (k == 20000) begin
			failures++;
			summarize();
		end else begin
			chk(c, n);
			@(posedge ref_clk);
		end
	endtask : ex

	// Read data compared one cycle after each read
	always @(posedge ref_clk) rd_seen <= reg_rd && rst_b;
	always @(negedge ref_clk) begin
		if (rd_seen)
			chk(reg_rdata, exp_q.pop_front());
	end

	// Main sequence
	initial begin
		{reg_wr, reg_rd, cap_load, train_active, train_err} = 5'h0;
		{train_done, exit_l0s, exit_l1, slow} = 4'h0;
		{reg_addr, reg_wdata, err_det} = 44'h0;
		{cap_load_aspm, cap_load_l0s, cap_load_l1} = 8'h0;
		neg_speed = 4'h1;
		neg_width = 6'h01;
		aux_pwr_det = 1'b1;
		rst_b = 1'b0;
		seed = 32'h0001_5a27;
		failures = 0;
		checked = 0;
		fl = 4'h0;
		rst();
		r = xs();
		acc(1, 8'hec, r);
		{cap_load_l1, cap_load_l0s, cap_load_aspm} <= r[7:0];
		cap_load <= 1'b1;
		idle(1);
		cap_load <= 1'b0;
		acc(0, 8'hec, {14'h0, r[7:0], 10'h011});
		idle(1);
		for (int i = 0; i < 4; i++) begin
			r = xs();
			w = xs();
			det = w[3:0] | (4'h1 << i);
			acc(1, 8'he8, r);
			fl = (fl & ~r[19:16]) | det;
			err_det <= det;
			aux_pwr_det <= w[31];
			idle(1);
			err_det <= 4'h0;
			@(negedge ref_clk);
			chk(err_msg, det & r[3:0]);
			@(posedge ref_clk);
			acc(0, 8'he8, {11'h0, w[31], fl, 12'h0, r[3:0]});
			acc(1, 8'he8, w);
			fl = fl & ~w[19:16];
			acc(0, 8'he8, {11'h0, w[31], fl, 12'h0, w[3:0]});
		end
		// Error event and clear in one cycle: the set wins
		err_det <= 4'hf;
		acc(1, 8'he8, 32'h000f_0000);
		err_det <= 4'h0;
		acc(0, 8'he8, {11'h0, w[31], 4'hf, 16'h0});
		acc(1, 8'he8, 32'h000f_0000);
		acc(0, 8'he8, {11'h0, w[31], 20'h0});
		$display("test errors done");
		for (int i = 0; i < 4; i++) begin
			r = xs();
			acc(1, 8'hf0, {r[31:2], i[1:0]});
			acc(0, 8'hf0, {16'h0011, 8'h0, r[7:4], 2'h0, i[1:0]});
			idle(2);
			@(negedge ref_clk);
			chk({aspm_l1_en, aspm_l0s_en}, i[1:0]);
			chk({common_clk, retrain_link, link_disable}, r[6:4]);
			chk(rx_l0s_en, 1'b1);
			@(posedge ref_clk);
		end
		$display("test control done");
		train_active <= 1'b1;
		train_err <= 1'b1;
		acc(1, 8'hf0, 32'h0);
		train_err <= 1'b0;
		idle(1);
		acc(0, 8'hf0, 32'h0c11_0000);
		w = xs();
		neg_width <= w[5:0];
		train_done <= 1'b1;
		idle(1);
		train_done <= 1'b0;
		train_active <= 1'b0;
		idle(1);
		acc(0, 8'hf0, {6'h0, w[5:0], 4'h1, 16'h0});
		idle(1);
		$display("test training done");
		for (int i = 0; i < 4; i++)
			ex(i[0], i[1], i[0] ? TN : FN);
		acc(1, 8'hf0, 32'h0000_0080);
		idle(1);
		ex(1'b0, 1'b0, 4096);
		ex(1'b1, 1'b1, 1024);
		$display("test exits done");
		rst();
		summarize();
	end
endmodule : pls_regs_tb_top

`default_nettype wire
